// ---- verilog/uia_pkg.sv ----
// Package for the indexed register access block of one serial channel
package uia_pkg;
    // Channel addresses
    localparam logic [2:0] A_DIV_LO   = 3'h0;
    localparam logic [2:0] A_EXTRA    = 3'h1;
    localparam logic [2:0] A_LINE_FMT = 3'h3;
    localparam logic [2:0] A_WINDOW   = 3'h5;
    localparam logic [2:0] A_SCRATCH  = 3'h7;
    // Indexed offsets
    localparam logic [7:0] IX_ACR  = 8'h00;
    localparam logic [7:0] IX_CPR  = 8'h01;
    localparam logic [7:0] IX_TCR  = 8'h02;
    localparam logic [7:0] IX_CKS  = 8'h03;
    localparam logic [7:0] IX_TTL  = 8'h04;
    localparam logic [7:0] IX_RTL  = 8'h05;
    localparam logic [7:0] IX_FCL  = 8'h06;
    localparam logic [7:0] IX_FCH  = 8'h07;
    localparam logic [7:0] IX_ID1  = 8'h08;
    localparam logic [7:0] IX_ID2  = 8'h09;
    localparam logic [7:0] IX_ID3  = 8'h0A;
    localparam logic [7:0] IX_REV  = 8'h0B;
    localparam logic [7:0] IX_SRST = 8'h0C;
    localparam logic [7:0] IX_NMR  = 8'h0D;
    localparam logic [7:0] IX_MDM  = 8'h0E;
    localparam logic [7:0] IX_RFC  = 8'h0F;
    localparam logic [7:0] IX_GDS  = 8'h10;
    localparam logic [7:0] IX_PORT_NUMBER = 8'h12;
    localparam logic [7:0] IX_CKA  = 8'h13;
    // Field positions and special values
    localparam int         ACR_IDX_RD_BIT = 6;
    localparam int         ACR_EXTRA_BIT  = 7;
    localparam int         LCR_DIV_BIT    = 7;
    localparam logic [7:0] LCR_650_KEY    = 8'hBF;
    localparam logic [7:0] SRST_CMD       = 8'h00;
    localparam logic [1:0] EXTRA_WR_MASK  = 2'h3;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CPR  = 8'h20;
    localparam logic [7:0] RST_DLL  = 8'h01;

    typedef struct packed {
        logic [7:0] additional_control;
        logic [7:0] baud_prescaler;
        logic [7:0] oversample_times_ctrl;
        logic [7:0] clock_source_select;
        logic [7:0] ttl;
        logic [7:0] rx_irq_threshold;
        logic [7:0] flow_low_threshold;
        logic [7:0] flow_high_threshold;
        logic [7:0] ninth_bit_ctrl;
        logic [7:0] wakeup_disable_mask;
        logic [7:0] clock_invert_ctrl;
    } uia_idx_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } uia_bus_t;

    typedef struct packed {
        logic [7:0] scratch_index;
        logic [7:0] line_format_ctrl;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic [1:0] tx_dis;
        logic [7:0] rdata;
        logic       rvalid;
    } uia_main_t;

    typedef struct packed {
        uia_idx_t   idx;
        logic [7:0] line_format_ctrl;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic [1:0] tx_dis;
    } uia_cfg_t;

    // Offsets that a window write may touch
    function automatic logic uia_defined(input logic [7:0] ix);
        uia_defined = (ix <= IX_GDS) || (ix == IX_PORT_NUMBER) || (ix == IX_CKA);
    endfunction
endpackage : uia_pkg

// ---- verilog/uia_idx_bank.sv ----
// Writable indexed control registers with their reset values
module uia_idx_bank
    import uia_pkg::*;
(
    input  wire logic       clk_i,    // Clock
    input  wire logic       nrst_i,   // Async reset, low
    input  wire logic       wr_i,     // Write strobe
    input  wire logic       srst_i,   // Channel soft reset
    input  wire logic [7:0] idx_i,    // Selected offset
    input  wire logic [7:0] wdata_i,  // Write data
    output logic [7:0]      rdata_o,  // Readback of selected flop
    output uia_idx_t        regs_o    // All register contents
);
    uia_idx_t bank_q;
    uia_idx_t bank_d;

    always_comb begin
        bank_d = bank_q;
        if (srst_i) begin
            bank_d     = '0;
            bank_d.baud_prescaler = RST_CPR;
            bank_d.clock_source_select = bank_q.clock_source_select;
        end else if (wr_i) begin
            case (idx_i)
                IX_ACR:  bank_d.additional_control = wdata_i;
                IX_CPR:  bank_d.baud_prescaler = wdata_i;
                IX_TCR:  bank_d.oversample_times_ctrl = wdata_i;
                IX_CKS:  bank_d.clock_source_select = wdata_i;
                IX_TTL:  bank_d.ttl = wdata_i;
                IX_RTL:  bank_d.rx_irq_threshold = wdata_i;
                IX_FCL:  bank_d.flow_low_threshold = wdata_i;
                IX_FCH:  bank_d.flow_high_threshold = wdata_i;
                IX_NMR:  bank_d.ninth_bit_ctrl = wdata_i;
                IX_MDM:  bank_d.wakeup_disable_mask = wdata_i;
                IX_CKA:  bank_d.clock_invert_ctrl = wdata_i;
                default: bank_d = bank_q;
            endcase
        end
    end

    always_comb begin
        case (idx_i)
            IX_ACR:  rdata_o = bank_q.additional_control;
            IX_CPR:  rdata_o = bank_q.baud_prescaler;
            IX_TCR:  rdata_o = bank_q.oversample_times_ctrl;
            IX_CKS:  rdata_o = bank_q.clock_source_select;
            IX_TTL:  rdata_o = bank_q.ttl;
            IX_RTL:  rdata_o = bank_q.rx_irq_threshold;
            IX_FCL:  rdata_o = bank_q.flow_low_threshold;
            IX_FCH:  rdata_o = bank_q.flow_high_threshold;
            IX_NMR:  rdata_o = bank_q.ninth_bit_ctrl;
            IX_MDM:  rdata_o = bank_q.wakeup_disable_mask;
            IX_CKA:  rdata_o = bank_q.clock_invert_ctrl;
            default: rdata_o = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bank_q     <= '0;
            bank_q.baud_prescaler <= RST_CPR;
        end else begin
            bank_q <= bank_d;
        end
    end

    assign regs_o = bank_q;
endmodule // uia_idx_bank

// ---- verilog/uia_regs.sv ----
// Channel register access: line format, scratch index, window and extra status
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - An access at address 101b reaches the indexed register named by the last index at 111b.
// - A window read gives the indexed register when bit 6 of additional control is set, else line status.
// - Registers needing additional control bit 7 set or clear are seen only in that state.
// - While the last line format write was 0xBF only the line format register is reachable.
// - Only bits 0 and 1 of the extra status register take writes; the rest stay status.
// - Writing 0x00 to the soft reset register resets the channel except clock source select.
// - Hardware reset clears writable registers, prescaler to 0x20 and divisor low to 0x01.
module uia_regs
    import uia_pkg::*;
#(
    parameter logic [7:0] ID_ONE   = 8'hA1,  // Arbitrary identity value
    parameter logic [7:0] ID_TWO   = 8'hA2,  // Arbitrary identity value
    parameter logic [7:0] ID_THREE = 8'hA3,  // Arbitrary identity value
    parameter logic [7:0] REV_ID   = 8'hA4   // Arbitrary revision value
) (
    input  wire logic       clk_i,          // Clock, 40 MHz
    input  wire logic       nrst_i,         // Async reset, low
    input  uia_bus_t        bus_i,          // Channel register access
    input  wire logic [7:0] line_status_i,  // Line status from channel
    input  wire logic [5:0] extra_stat_i,   // Extra status bits 7:2
    input  wire logic [7:0] fifo_setup_i,   // FIFO setup readback
    input  wire logic       good_data_i,    // Good data status
    input  wire logic [1:0] port_index_i,   // Hardwired channel number
    output logic [7:0]      rdata_o,        // Read data
    output logic            rvalid_o,       // Read data valid pulse
    output logic            soft_rst_o,     // Soft reset pulse
    output uia_cfg_t        cfg_o           // Configuration to channel
);
    ////////////////////////////////////////////////////////////////////////////
    uia_main_t  st_q;
    uia_main_t  st_d;
    uia_idx_t   idx_regs;
    logic [7:0] bank_rdata;
    logic [7:0] idx_rdata;
    logic       key650;
    logic       div_acc;
    logic       extra_acc;
    logic       win_wr;
    logic       srst;
    logic [7:0] rd_mux;

    // Key is held in the line format register, so it ends at the next write there
    assign key650    = (st_q.line_format_ctrl == LCR_650_KEY);
    assign div_acc   = st_q.line_format_ctrl[LCR_DIV_BIT] && !key650;
    assign extra_acc = !st_q.line_format_ctrl[LCR_DIV_BIT] && !key650
                       && idx_regs.additional_control[ACR_EXTRA_BIT];
    assign win_wr    = bus_i.wr && (bus_i.addr == A_WINDOW) && !key650;
    assign srst      = win_wr && (st_q.scratch_index == IX_SRST)
                       && (bus_i.wdata == SRST_CMD);

    uia_idx_bank u_bank (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .wr_i    (win_wr && uia_defined(st_q.scratch_index)),
        .srst_i  (srst),
        .idx_i   (st_q.scratch_index),
        .wdata_i (bus_i.wdata),
        .rdata_o (bank_rdata),
        .regs_o  (idx_regs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read-only indexed values
    always_comb begin
        case (st_q.scratch_index)
            IX_ID1:  idx_rdata = ID_ONE;
            IX_ID2:  idx_rdata = ID_TWO;
            IX_ID3:  idx_rdata = ID_THREE;
            IX_REV:  idx_rdata = REV_ID;
            IX_RFC:  idx_rdata = fifo_setup_i;
            IX_GDS:  idx_rdata = {7'h00, good_data_i};
            IX_PORT_NUMBER: idx_rdata = {6'h00, port_index_i};
            default: idx_rdata = bank_rdata;
        endcase
    end

    always_comb begin
        rd_mux = RST_ZERO;
        case (bus_i.addr)
            A_DIV_LO: begin
                if (div_acc) begin
                    rd_mux = st_q.dll;
                end
            end
            A_EXTRA: begin
                if (div_acc) begin
                    rd_mux = st_q.dlm;
                end else if (extra_acc) begin
                    rd_mux = {extra_stat_i, st_q.tx_dis};
                end
            end
            A_LINE_FMT: rd_mux = st_q.line_format_ctrl;
            A_WINDOW: begin
                if (key650) begin
                    rd_mux = RST_ZERO;
                end else if (idx_regs.additional_control[ACR_IDX_RD_BIT]) begin
                    rd_mux = idx_rdata;
                end else begin
                    rd_mux = line_status_i;
                end
            end
            A_SCRATCH: begin
                if (!key650) begin
                    rd_mux = st_q.scratch_index;
                end
            end
            default: rd_mux = RST_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = bus_i.rd;
        if (bus_i.rd) begin
            st_d.rdata = rd_mux;
        end
        if (srst) begin
            st_d.scratch_index    = RST_ZERO;
            st_d.line_format_ctrl    = RST_ZERO;
            st_d.dll    = RST_DLL;
            st_d.dlm    = RST_ZERO;
            st_d.tx_dis = '0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                A_DIV_LO: begin
                    if (div_acc) begin
                        st_d.dll = bus_i.wdata;
                    end
                end
                A_EXTRA: begin
                    if (div_acc) begin
                        st_d.dlm = bus_i.wdata;
                    end else if (extra_acc) begin
                        st_d.tx_dis = bus_i.wdata[1:0] & EXTRA_WR_MASK;
                    end
                end
                A_LINE_FMT: st_d.line_format_ctrl = bus_i.wdata;
                A_SCRATCH: begin
                    if (!key650) begin
                        st_d.scratch_index = bus_i.wdata;
                    end
                end
                default: st_d.scratch_index = st_q.scratch_index;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q     <= '0;
            st_q.dll <= RST_DLL;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o       = st_q.rdata;
    assign rvalid_o      = st_q.rvalid;
    assign soft_rst_o    = srst;
    assign cfg_o.idx     = idx_regs;
    assign cfg_o.line_format_ctrl     = st_q.line_format_ctrl;
    assign cfg_o.dll     = st_q.dll;
    assign cfg_o.dlm     = st_q.dlm;
    assign cfg_o.tx_dis  = st_q.tx_dis;
endmodule // uia_regs

// ---- tb/uia_regs_checker.sv ----
// Concurrent checks on the channel register access ports
module uia_regs_checker
    import uia_pkg::*;
(
    input  wire logic       clk_i,          // Clock
    input  wire logic       nrst_i,         // Async reset, low
    input  uia_bus_t        bus_i,          // Register access
    input  wire logic [7:0] line_status_i,  // Line status
    input  wire logic [7:0] rdata_o,        // Read data
    input  wire logic       rvalid_o,       // Read valid
    input  wire logic       soft_rst_o,     // Soft reset pulse
    input  uia_cfg_t        cfg_o           // Configuration
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////
    wire logic bf = (cfg_o.line_format_ctrl == LCR_650_KEY);
    a_read_answer: assert property (bus_i.rd |=> rvalid_o)
        else $error("read not answered next cycle");
    a_no_spurious: assert property (!bus_i.rd |=> !rvalid_o)
        else $error("read valid without a read");
    a_rdata_holds: assert property (!rvalid_o |-> $stable(rdata_o))
        else $error("read data moved between reads");
    a_status_view: assert property (bus_i.rd && bus_i.addr == A_WINDOW && !bf
        && !cfg_o.idx.additional_control[ACR_IDX_RD_BIT] |=> rdata_o == $past(line_status_i))
        else $error("window read did not give line status");
    a_key_blocks: assert property (bf && bus_i.wr && bus_i.addr == A_WINDOW
        |=> $stable(cfg_o.idx))
        else $error("window write taken under 650 key");
    a_key_zero: assert property (bf && bus_i.rd && bus_i.addr == A_SCRATCH
        |=> rdata_o == 8'h00)
        else $error("scratch readable under 650 key");
    a_extra_mask: assert property (bus_i.wr && bus_i.addr == A_EXTRA && !bf
        && !cfg_o.line_format_ctrl[LCR_DIV_BIT] && cfg_o.idx.additional_control[ACR_EXTRA_BIT]
        |=> cfg_o.tx_dis == $past(bus_i.wdata[1:0]))
        else $error("extra status write bits wrong");
    a_extra_hidden: assert property (bus_i.wr && bus_i.addr == A_EXTRA
        && !cfg_o.idx.additional_control[ACR_EXTRA_BIT] && !cfg_o.line_format_ctrl[LCR_DIV_BIT]
        |=> $stable(cfg_o.tx_dis))
        else $error("extra status written while hidden");
    a_soft_reset: assert property (soft_rst_o |=> cfg_o.idx.baud_prescaler == RST_CPR
        && cfg_o.dll == RST_DLL && cfg_o.line_format_ctrl == 8'h00 && cfg_o.idx.oversample_times_ctrl == 8'h00
        && cfg_o.idx.clock_source_select == $past(cfg_o.idx.clock_source_select))
        else $error("soft reset result wrong");
    c_soft: cover property (soft_rst_o);
    c_idx_read: cover property (rvalid_o && cfg_o.idx.additional_control[ACR_IDX_RD_BIT]);
    c_key_write: cover property (bf && bus_i.wr && bus_i.addr == A_WINDOW);
endmodule // uia_regs_checker

bind uia_regs uia_regs_checker chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i),
    .line_status_i(line_status_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .soft_rst_o(soft_rst_o), .cfg_o(cfg_o));

// ---- tb/tb.sv ----
// Self-checking bench for the channel register access block
module tb
    import uia_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] P1 = 8'h3C, P2 = 8'h4D, P3 = 8'h5E, P4 = 8'h6F; // Arbitrary
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    uia_bus_t   bus_i = '0;
    logic [7:0] ls = 8'h00, fs = 8'h00, rdata_o, v, e;
    logic [5:0] es = 6'h00;
    logic       gd = 1'b0, rvalid_o, soft_rst_o;
    logic [1:0] pi = 2'h0;
    uia_cfg_t   cfg_o;
    logic [7:0] exp_q[$];
    logic [7:0] em[0:19];
    logic [31:0] seed = 32'd96227;
    int         bad_count = 0, checks_done = 0;
    always #12.5 clk_i = ~clk_i;
    uia_regs #(.ID_ONE(P1), .ID_TWO(P2), .ID_THREE(P3), .REV_ID(P4)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .line_status_i(ls),
        .extra_stat_i(es), .fifo_setup_i(fs), .good_data_i(gd), .port_index_i(pi),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .soft_rst_o(soft_rst_o), .cfg_o(cfg_o));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
        checks_done++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic put(input logic [2:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clk_i);
        #2;
        bus_i = '{addr: a, wdata: d, wr: w, rd: r};
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        put(a, d, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        put(a, 8'h00, 1'b0, 1'b1);
        exp_q.push_back(x);
    endtask
    task automatic settle();
        put(3'h0, 8'h00, 1'b0, 1'b0);
        @(negedge clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Results land one cycle after the read; look at them mid-cycle
    always @(negedge clk_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) chk("spare_valid", 8'h01, 8'h00);
            else chk("rdata", rdata_o, exp_q.pop_front());
        end
    end
    initial begin
        #(25 * 5000);
        bad_count++;
        conclude();
    end
    initial begin
        seed = lfsr(seed);
        {pi, gd, es, fs, ls} = seed[24:0];
        repeat (6) @(posedge clk_i);
        #2 nrst_i = 1'b1;
        @(negedge clk_i);
        chk("cpr_rst", cfg_o.idx.baud_prescaler, RST_CPR);
        chk("dll_rst", cfg_o.dll, RST_DLL);
        chk("acr_rst", cfg_o.idx.additional_control, RST_ZERO);
        wr(A_SCRATCH, IX_ACR);
        wr(A_WINDOW, 8'h40);
        for (int i = 1; i < 20; i++) begin
            seed = lfsr(seed);
            v = seed[7:0] | {7'h0, i == 12}; // Nonzero so no soft reset here
            case (i)
                8: e = P1;
                9: e = P2;
                10: e = P3;
                11: e = P4;
                12, 17: e = 8'h00;
                15: e = fs;
                16: e = {7'h0, gd};
                18: e = {6'h0, pi};
                default: e = v;
            endcase
            em[i] = e;
            wr(A_SCRATCH, 8'(i));
            wr(A_WINDOW, v);
            rd(A_WINDOW, e);
        end
        settle();
        chk("cpr_kept", cfg_o.idx.baud_prescaler, em[1]);
        wr(A_SCRATCH, IX_ACR);
        wr(A_WINDOW, 8'hC0);
        wr(A_EXTRA, 8'hFF);
        rd(A_EXTRA, {es, EXTRA_WR_MASK});
        wr(A_WINDOW, 8'h40);
        rd(A_EXTRA, 8'h00);
        wr(A_WINDOW, 8'h00);
        rd(A_WINDOW, ls);
        wr(A_LINE_FMT, LCR_650_KEY);
        wr(A_WINDOW, 8'h55);
        rd(A_SCRATCH, 8'h00);
        rd(A_WINDOW, 8'h00);
        settle();
        chk("acr_key", cfg_o.idx.additional_control, 8'h00);
        wr(A_LINE_FMT, 8'h80);
        wr(A_DIV_LO, 8'h5A);
        rd(A_DIV_LO, 8'h5A);
        wr(A_LINE_FMT, 8'h00);
        wr(A_SCRATCH, IX_SRST);
        wr(A_WINDOW, SRST_CMD);
        @(negedge clk_i);
        chk("srst_pulse", {7'h00, soft_rst_o}, 8'h01);
        settle();
        chk("cks_kept", cfg_o.idx.clock_source_select, em[3]);
        chk("cpr_srst", cfg_o.idx.baud_prescaler, RST_CPR);
        chk("tcr_srst", cfg_o.idx.oversample_times_ctrl, 8'h00);
        chk("dll_srst", cfg_o.dll, RST_DLL);
        repeat (3) @(posedge clk_i);
        chk("unanswered", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule // tb
